//--- shared/bcd_unit_defines.svh
// Constants for the decimal adjust, decrement, interrupt disable and divide unit.
`ifndef BCD_UNIT_DEFINES_SVH
`define BCD_UNIT_DEFINES_SVH
`define ADJ_NONE 8'h00
`define ADJ_ADD_LO 8'h06
`define ADJ_ADD_HI 8'h60
`define ADJ_ADD_BOTH 8'h66
`define ADJ_SUB_LO 8'hfa
`define ADJ_SUB_HI 8'ha0
`define ADJ_SUB_BOTH 8'h9a
`define NIB_NINE 4'h9
`define NIB_EIGHT 4'h8
`define NIB_TWO 4'h2
`define NIB_THREE 4'h3
`define NIB_SIX 4'h6
`define NIB_SEVEN 4'h7
`define DIV_CYCLES_ZERO 10
`define DIV_CYCLES_NORMAL 26
`define DIV_MIN_ZERO 2
`define DIV_MIN_NORMAL 11
`define DIV_MAX_CYCLES 32
`define SYM_IE_BIT 0
`define BYTE_MSB 7
`define WORD_MSB 15
`endif

//--- shared/bcd_unit_pkg.sv
// Types shared by the decimal adjust, decrement, interrupt disable and divide unit.
package bcd_unit_pkg;
  typedef enum logic [2:0] {
    op_decimal_adjust,
    op_byte_decrement,
    op_word_decrement,
    op_interrupt_disable,
    op_divide,
    op_none
  } op_sel_t;
  typedef enum logic [1:0] {
    st_idle,
    st_divide,
    st_finish
  } unit_state_t;
endpackage

//--- rtl/bcd_adjust_decrement_divide_unit.sv
// Execution datapath for decimal adjust, decrements, interrupt disable and unsigned divide.
// How it works
// - Add-side adjust adds 00/06/60/66, sets carry.
// - Subtract-side adjust adds 00/FA/A0/9A, sets carry.
// - Non-BCD input gives an unspecified adjust result.
// - Adjust flags: carry, zero, sign; V undefined.
// - Byte decrement updates Z, S, V only.
// - Word decrement over pair updates Z, S, V.
// - Interrupt disable clears mode bit zero only.
// - Pending bits still set while disabled; no service.
// - Divide 16 by 8; remainder high, quotient low.
// - Divide operands are unsigned only.
// - Overflow on quotient above 255 or zero divisor.
// - Carry when overflow and quotient 256..511.
// - Zero on zero divisor/quotient; sign from quotient MSB.
// - Divide takes 10 cycles, or 26 cycles.
`timescale 1ns/1ps
`include "bcd_unit_defines.svh"

module bcd_adjust_decrement_divide_unit #(
  parameter int DIV_ZERO_CYCLES = `DIV_CYCLES_ZERO,
  parameter int DIV_NORMAL_CYCLES = `DIV_CYCLES_NORMAL
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Operation request; start is a one-cycle pulse taken while busy_o is low.
  input wire logic start_i,
  input wire logic [2:0] op_i,
  input wire logic sub_mode_i,
  // Operands from the register file.
  input wire logic [15:0] dst_i,
  input wire logic [7:0] src_i,
  // Flags before the operation.
  input wire logic carry_i,
  input wire logic zero_i,
  input wire logic sign_i,
  input wire logic overflow_i,
  input wire logic half_carry_i,
  // Interrupt enable control and requests.
  input wire logic global_enable_set_i,
  input wire logic [7:0] irq_i,
  input wire logic [7:0] pending_clear_i,
  // Results.
  output logic [15:0] result_o,
  output logic result_word_o,
  output logic done_o,
  output logic busy_o,
  output logic carry_o,
  output logic zero_o,
  output logic sign_o,
  output logic overflow_o,
  // Interrupt state.
  output logic system_mode_ie_o,
  output logic [7:0] pending_o,
  output logic service_req_o
);

  // The cycle counter is five bits wide, and a normal divide needs its nine step cycles plus
  // one settled cycle before the result is taken, so other counts cannot be served.
  if (DIV_ZERO_CYCLES < `DIV_MIN_ZERO || DIV_ZERO_CYCLES > DIV_NORMAL_CYCLES
      || DIV_NORMAL_CYCLES < `DIV_MIN_NORMAL
      || DIV_NORMAL_CYCLES > `DIV_MAX_CYCLES) begin : g_bad_counts
    $error("Divide cycle counts cannot be served.");
  end

  // Counter end points; the count reads one in the first cycle after the take edge.
  localparam logic [4:0] ZERO_CNT = 5'(DIV_ZERO_CYCLES - 1);
  localparam logic [4:0] NORM_CNT = 5'(DIV_NORMAL_CYCLES - 1);

  // Decimal adjust correction; outputs of invalid BCD are unspecified so any value is fine.
  function automatic logic [8:0] adjust(input logic sub, input logic c, input logic h,
                                        input logic [7:0] v);
    logic [3:0] hi;
    logic [3:0] lo;
    logic [7:0] add;
    logic cout;
    hi = v[7:4];
    lo = v[3:0];
    add = `ADJ_NONE;
    cout = 1'b0;
    if (!sub) begin
      if (!c) begin
        if (!h && hi <= `NIB_NINE && lo <= `NIB_NINE) add = `ADJ_NONE;
        else if (!h && hi <= `NIB_EIGHT && lo > `NIB_NINE) add = `ADJ_ADD_LO;
        else if (h && hi <= `NIB_NINE && lo <= `NIB_THREE) add = `ADJ_ADD_LO;
        else if (!h && hi > `NIB_NINE && lo <= `NIB_NINE) begin
          add = `ADJ_ADD_HI;
          cout = 1'b1;
        end else begin
          add = `ADJ_ADD_BOTH;
          cout = 1'b1;
        end
      end else begin
        cout = 1'b1;
        if (!h && hi <= `NIB_TWO && lo <= `NIB_NINE) add = `ADJ_ADD_HI;
        else add = `ADJ_ADD_BOTH;
      end
    end else begin
      // Subtraction side: each correction is the negative of its addition counterpart.
      if (!c) begin
        if (h && lo >= `NIB_SIX) add = `ADJ_SUB_LO;
        else add = `ADJ_NONE;
      end else begin
        cout = 1'b1;
        if (h && lo >= `NIB_SIX && hi >= `NIB_SIX) add = `ADJ_SUB_BOTH;
        else add = `ADJ_SUB_HI;
      end
    end
    adjust = {cout, 8'(v + add)};
  endfunction

  bcd_unit_pkg::unit_state_t state;
  logic [4:0] cycle_cnt;
  logic [4:0] cycle_end;
  logic [15:0] div_rem;
  logic [8:0] div_quot;
  logic [7:0] divisor;
  logic [3:0] bit_idx;
  logic div_by_zero;
  logic [16:0] trial;

  // Operation decode of the request.
  bcd_unit_pkg::op_sel_t op_sel;
  always_comb begin
    case (op_i)
      3'h0: op_sel = bcd_unit_pkg::op_decimal_adjust;
      3'h1: op_sel = bcd_unit_pkg::op_byte_decrement;
      3'h2: op_sel = bcd_unit_pkg::op_word_decrement;
      3'h3: op_sel = bcd_unit_pkg::op_interrupt_disable;
      3'h4: op_sel = bcd_unit_pkg::op_divide;
      default: op_sel = bcd_unit_pkg::op_none;
    endcase
  end

  // A request is taken only from idle, so a start during a divide is dropped without notice.
  logic take;
  assign take = start_i && state == bcd_unit_pkg::st_idle;

  // Restoring step: a clear borrow bit means the shifted divisor fits into the remainder.
  assign trial = {1'b0, div_rem} - {1'b0, 16'({8'h00, divisor} << bit_idx)};

  // Sequencer: single-cycle ops finish next edge; divide counts its fixed latency.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= bcd_unit_pkg::st_idle;
      cycle_cnt <= 5'h00;
      cycle_end <= 5'h00;
    end else begin
      case (state)
        bcd_unit_pkg::st_idle: begin
          cycle_cnt <= 5'h01;
          if (take && op_sel == bcd_unit_pkg::op_divide) begin
            state <= bcd_unit_pkg::st_divide;
            cycle_end <= (src_i == 8'h00) ? ZERO_CNT : NORM_CNT;
          end
        end
        bcd_unit_pkg::st_divide: begin
          cycle_cnt <= cycle_cnt + 5'h01;
          if (cycle_cnt == cycle_end) state <= bcd_unit_pkg::st_idle;
        end
        default: state <= bcd_unit_pkg::st_idle;
      endcase
    end
  end

  // Divider datapath: one quotient bit per cycle, MSB first, all unsigned.
  // A zero divisor skips the steps, so the stored pair is left as loaded.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_rem <= 16'h0000;
      div_quot <= 9'h000;
      divisor <= 8'h00;
      bit_idx <= 4'h0;
      div_by_zero <= 1'b0;
    end else if (take && op_sel == bcd_unit_pkg::op_divide) begin
      div_rem <= dst_i;
      divisor <= src_i;
      div_quot <= 9'h000;
      bit_idx <= 4'h8;
      div_by_zero <= (src_i == 8'h00);
    end else if (state == bcd_unit_pkg::st_divide && !div_by_zero && bit_idx != 4'hf) begin
      // Subtract the divisor shifted to the current quotient bit whenever it fits.
      if (!trial[16] && bit_idx <= 4'h8) begin
        div_rem <= trial[15:0];
        div_quot[bit_idx] <= 1'b1;
      end
      bit_idx <= bit_idx - 4'h1;
    end
  end

  // Last counted cycle; results land on the same edge that ends the busy window.
  logic last_div;
  assign last_div = state == bcd_unit_pkg::st_divide && cycle_cnt == cycle_end;

  // Result and flag registers.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    logic [8:0] adj;
    logic [7:0] b;
    logic [15:0] w;
    if (!nrst_i) begin
      result_o <= 16'h0000;
      result_word_o <= 1'b0;
      done_o <= 1'b0;
      carry_o <= 1'b0;
      zero_o <= 1'b0;
      sign_o <= 1'b0;
      overflow_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      adj = adjust(sub_mode_i, carry_i, half_carry_i, dst_i[7:0]);
      b = 8'(dst_i[7:0] - 8'h01);
      w = 16'(dst_i - 16'h0001);
      // Untouched flags pass through from the inputs, so the caller can write all of them back.
      if (take) begin
        done_o <= op_sel != bcd_unit_pkg::op_divide;
        carry_o <= carry_i;
        zero_o <= zero_i;
        sign_o <= sign_i;
        overflow_o <= overflow_i;
        case (op_sel)
          bcd_unit_pkg::op_decimal_adjust: begin
            result_o <= {8'h00, adj[7:0]};
            result_word_o <= 1'b0;
            carry_o <= adj[8];
            zero_o <= adj[7:0] == 8'h00;
            sign_o <= adj[`BYTE_MSB];
          end
          bcd_unit_pkg::op_byte_decrement: begin
            result_o <= {8'h00, b};
            result_word_o <= 1'b0;
            zero_o <= b == 8'h00;
            sign_o <= b[`BYTE_MSB];
            overflow_o <= dst_i[7:0] == 8'h80;
          end
          bcd_unit_pkg::op_word_decrement: begin
            result_o <= w;
            result_word_o <= 1'b1;
            zero_o <= w == 16'h0000;
            sign_o <= w[`WORD_MSB];
            overflow_o <= dst_i == 16'h8000;
          end
          default: begin
            result_word_o <= 1'b0;
          end
        endcase
      end else if (last_div) begin
        done_o <= 1'b1;
        result_word_o <= 1'b1;
        result_o <= {div_rem[7:0], div_quot[7:0]};
        overflow_o <= div_by_zero || div_quot[8] || div_rem[15:8] >= divisor;
        // A quotient of 512 or more leaves a final remainder no smaller than the divisor.
        carry_o <= !div_by_zero && div_quot[8] && div_rem < {8'h00, divisor};
        zero_o <= div_by_zero || div_quot == 9'h000;
        sign_o <= div_quot[`BYTE_MSB];
      end
    end
  end

  // Global interrupt enable bit of the system mode register.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      system_mode_ie_o <= 1'b0;
    end else if (take && op_sel == bcd_unit_pkg::op_interrupt_disable) begin
      system_mode_ie_o <= 1'b0;
    end else if (global_enable_set_i) begin
      system_mode_ie_o <= 1'b1;
    end
  end

  // Pending bits keep latching while disabled; a new request wins over a clear.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pending_o <= 8'h00;
    end else begin
      pending_o <= (pending_o & ~pending_clear_i) | irq_i;
    end
  end

  // Service request only while enabled, so disabling holds off servicing.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      service_req_o <= 1'b0;
    end else begin
      service_req_o <= system_mode_ie_o && !(take && op_sel == bcd_unit_pkg::op_interrupt_disable)
                       && (pending_o != 8'h00);
    end
  end

  // Busy covers the whole divide, which is the window in which starts are ignored.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_o <= 1'b0;
    end else if (take && op_sel == bcd_unit_pkg::op_divide) begin
      busy_o <= 1'b1;
    end else if (last_div) begin
      busy_o <= 1'b0;
    end
  end

endmodule

//--- tb/adj_unit_checker.sv
// Concurrent checks on the ports of the adjust, decrement and divide unit.
`timescale 1ns/1ps
module adj_unit_checker #(
  parameter int DIV_ZERO_CYCLES = 10,
  parameter int DIV_NORMAL_CYCLES = 26
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic [2:0] op_i,
  input wire logic [15:0] dst_i,
  input wire logic [7:0] src_i,
  input wire logic carry_i,
  input wire logic [7:0] irq_i,
  input wire logic [15:0] result_o,
  input wire logic done_o,
  input wire logic busy_o,
  input wire logic carry_o,
  input wire logic zero_o,
  input wire logic sign_o,
  input wire logic overflow_o,
  input wire logic system_mode_ie_o,
  input wire logic [7:0] pending_o,
  input wire logic service_req_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // A request only counts when the unit is not busy with a divide.
  wire logic take = start_i && !busy_o;
  AST_ADJ_FLAGS: assert property (take && op_i == 3'h0 |=> done_o &&
    zero_o == (result_o[7:0] == 8'h00) && sign_o == result_o[7])
    else $error("adjust flags wrong");
  AST_DEC_BYTE: assert property (take && op_i == 3'h1 |=> done_o &&
    result_o[7:0] == $past(dst_i[7:0]) - 8'h01 && carry_o == $past(carry_i))
    else $error("byte decrement wrong");
  AST_DEC_WORD: assert property (take && op_i == 3'h2 |=>
    result_o == $past(dst_i) - 16'h0001 && zero_o == (result_o == 16'h0000)
    && sign_o == result_o[15])
    else $error("word decrement wrong");
  AST_DISABLE: assert property (take && op_i == 3'h3 |=>
    done_o && !system_mode_ie_o)
    else $error("disable left enable set");
  AST_NO_SERVICE: assert property (!system_mode_ie_o && !$past(system_mode_ie_o)
    |-> !service_req_o)
    else $error("service while disabled");
  AST_PEND_SET: assert property (irq_i != 8'h00 |=>
    (pending_o & $past(irq_i)) == $past(irq_i))
    else $error("pending bit not set");
  AST_DIV_BUSY: assert property (take && op_i == 3'h4 |=> busy_o [*8])
    else $error("divide not busy");
  AST_DIV_ZERO: assert property (take && op_i == 3'h4 && src_i == 8'h00 |->
    ##DIV_ZERO_CYCLES done_o && overflow_o && zero_o)
    else $error("zero divide timing or flags");
  AST_DIV_TIME: assert property (take && op_i == 3'h4 && src_i != 8'h00 |->
    ##DIV_NORMAL_CYCLES done_o)
    else $error("divide timing wrong");
  AST_DIV_CARRY: assert property (done_o && $past(busy_o) && carry_o
    |-> overflow_o)
    else $error("carry without overflow");
  // Main scenarios.
  cover property (take && op_i == 3'h4);
  cover property (take && op_i == 3'h0);
  cover property (service_req_o);
endmodule
bind bcd_adjust_decrement_divide_unit adj_unit_checker #(.DIV_ZERO_CYCLES(DIV_ZERO_CYCLES),
  .DIV_NORMAL_CYCLES(DIV_NORMAL_CYCLES)) chk_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
  .start_i(start_i), .op_i(op_i), .dst_i(dst_i), .src_i(src_i), .carry_i(carry_i),
  .irq_i(irq_i), .result_o(result_o), .done_o(done_o), .busy_o(busy_o), .carry_o(carry_o),
  .zero_o(zero_o), .sign_o(sign_o), .overflow_o(overflow_o),
  .system_mode_ie_o(system_mode_ie_o), .pending_o(pending_o), .service_req_o(service_req_o));

//--- tb/tb_top.sv
// Directed testbench for the adjust, decrement, interrupt disable and divide unit.
`timescale 1ns/1ps
module tb_top;
  logic clk, rst_n, start, sub, c_in, h_in, gen, rw, done, busy, co, zo, so, vo, ie, srv;
  logic [2:0] op;
  logic [15:0] dst, res;
  logic [7:0] src, irq, pclr, pend;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  bcd_adjust_decrement_divide_unit dut_u (.ref_clk_i(clk), .nrst_i(rst_n), .start_i(start),
    .op_i(op), .sub_mode_i(sub), .dst_i(dst), .src_i(src), .carry_i(c_in), .zero_i(1'b0),
    .sign_i(1'b0), .overflow_i(1'b0), .half_carry_i(h_in), .global_enable_set_i(gen),
    .irq_i(irq), .pending_clear_i(pclr), .result_o(res), .result_word_o(rw), .done_o(done),
    .busy_o(busy), .carry_o(co), .zero_o(zo), .sign_o(so), .overflow_o(vo),
    .system_mode_ie_o(ie), .pending_o(pend), .service_req_o(srv));
  // Free-running clock at 8 ns.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // The whole run needs well under 3000 cycles, so a hang is cut off here.
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      n_fail++;
      finish_test();
    end
  end
  task finish_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task cmp(string w, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", w, e, g);
    end
  endtask
  task cmp1(string w, logic e, logic g);
    cmp(w, {15'h0000, e}, {15'h0000, g});
  endtask
  // One operation; a second start during a divide must be ignored.
  task run(logic [2:0] o, logic s, logic [15:0] d, logic [7:0] v, logic c, logic h);
    int k;
    logic [15:0] n;
    @(negedge clk);
    {op, sub, dst, src, c_in, h_in, start} = {o, s, d, v, c, h, 1'b1};
    k = 0;
    do begin
      @(negedge clk);
      start = (o == 3'h4 && k == 3);
      k++;
    end while (done !== 1'b1 && k < 40);
    n = (o != 3'h4) ? 16'h0001 : (v == 8'h00) ? 16'h000a : 16'h001a;
    cmp("cycles", n, 16'(k));
  endtask
  task adj(logic s, logic [7:0] d, logic c, logic h, logic [7:0] e, logic ec);
    run(3'h0, s, {8'h00, d}, 8'h00, c, h);
    cmp("adj", {8'h00, e}, {8'h00, res[7:0]});
    cmp1("adj_c", ec, co);
    cmp1("adj_z", e == 8'h00, zo);
    cmp1("adj_s", e[7], so);
  endtask
  task dec(logic w, logic [15:0] d);
    logic [15:0] e;
    e = d - 16'h0001;
    run(w ? 3'h2 : 3'h1, 1'b0, d, 8'h00, 1'b1, 1'b0);
    if (w) begin
      cmp("dw", e, res);
      cmp1("dw_v", d == 16'h8000, vo);
      cmp1("dw_z", e == 16'h0000, zo);
      cmp1("dw_s", e[15], so);
      cmp1("dw_or", e == 16'h0000, (res[15:8] | res[7:0]) == 8'h00);
    end else begin
      cmp("db", {8'h00, e[7:0]}, {8'h00, res[7:0]});
      cmp1("db_v", d[7:0] == 8'h80, vo);
      cmp1("db_s", e[7], so);
      cmp1("db_z", e[7:0] == 8'h00, zo);
    end
    cmp1("dec_w", w, rw);
    cmp1("dec_c", 1'b1, co);
  endtask
  // Expected quotient is kept 17 bits wide so overflow bands can be told apart.
  task dv(logic [15:0] d, logic [7:0] v);
    logic [16:0] q;
    logic [15:0] r;
    logic ov;
    q = (v == 8'h00) ? 17'h00000 : {1'b0, d / {8'h00, v}};
    r = (v == 8'h00) ? 16'h0000 : d % {8'h00, v};
    ov = (v == 8'h00) || (q > 17'h000ff);
    run(3'h4, 1'b0, d, v, 1'b0, 1'b0);
    cmp1("dv_v", ov, vo);
    cmp1("dv_z", (v == 8'h00) || (q == 17'h00000), zo);
    cmp1("dv_c", ov && v != 8'h00 && q > 17'h000ff && q < 17'h00200, co);
    cmp1("dv_w", 1'b1, rw);
    if (!ov) cmp("dv_q", {r[7:0], q[7:0]}, res);
    if (!ov) cmp1("dv_s", q[7], so);
  endtask
  initial begin
    {rst_n, start, sub, c_in, h_in, gen, op, dst, src, irq, pclr} = '0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    cmp("rst", 16'h0000, {7'h00, ie, pend});
    adj(0, 8'h3c, 0, 0, 8'h42, 0);
    adj(0, 8'ha5, 0, 0, 8'h05, 1);
    adj(0, 8'h9b, 0, 0, 8'h01, 1);
    adj(0, 8'h9a, 0, 0, 8'h00, 1);
    adj(0, 8'hb2, 0, 1, 8'h18, 1);
    adj(0, 8'h31, 0, 1, 8'h37, 0);
    adj(0, 8'h25, 1, 0, 8'h85, 1);
    adj(0, 8'h2c, 1, 0, 8'h92, 1);
    adj(0, 8'h12, 1, 1, 8'h78, 1);
    adj(1, 8'h45, 0, 0, 8'h45, 0);
    adj(1, 8'h0f, 0, 1, 8'h09, 0);
    adj(1, 8'h75, 1, 0, 8'h15, 1);
    adj(1, 8'h8f, 1, 1, 8'h29, 1);
    dec(0, 16'h0000);
    dec(0, 16'h0080);
    dec(0, 16'h0001);
    dec(1, 16'h1234);
    dec(1, 16'h0001);
    dec(1, 16'h8000);
    dv(16'h1003, 8'h40);
    dv(16'h1003, 8'h80);
    dv(16'hfe01, 8'hff);
    dv(16'h0005, 8'h07);
    dv(16'hff00, 8'hff);
    dv(16'hffff, 8'h01);
    dv(16'h1234, 8'h00);
    gen = 1'b1;
    @(negedge clk) gen = 1'b0;
    irq = 8'h04;
    @(negedge clk) irq = 8'h00;
    repeat (2) @(negedge clk);
    cmp("pend", 16'h0104, {7'h00, ie, pend});
    cmp1("srv_on", 1'b1, srv);
    run(3'h3, 1'b0, 16'h0000, 8'h00, 1'b0, 1'b0);
    irq = 8'h10;
    @(negedge clk) irq = 8'h00;
    repeat (3) @(negedge clk);
    cmp("pend_di", 16'h0014, {7'h00, ie, pend});
    cmp1("srv_off", 1'b0, srv);
    pclr = 8'h14;
    @(negedge clk) pclr = 8'h00;
    @(negedge clk);
    cmp("pend_clr", 16'h0000, {8'h00, pend});
    finish_test();
  end
endmodule
